// ---- src/des_key_pkg.sv ----
package des_key_pkg;

	// Algorithm clock: a one-cycle enable derived from mclk.
	localparam int MCLK_HZ = 40_000_000;
	localparam int ALGO_HZ = 2_000_000;
	localparam int ALGO_DIV = MCLK_HZ / ALGO_HZ;
	localparam logic [4:0] ALGO_DIV_LAST = 5'(ALGO_DIV - 1);

	// Lengths in algorithm clock cycles.
	localparam logic [8:0] CYC_DATA = 9'h140;
	localparam logic [8:0] CYC_SKEY = 9'h148;
	localparam logic [8:0] CYC_XFER = 9'h008;

	localparam logic [2:0] KEY_BYTES_LAST = 3'h7;

	// Word index = {A2,A1,A0}; byte address = index * 4.
	localparam logic [2:0] IDX_STAGE = 3'h0;
	localparam logic [2:0] IDX_RESET = 3'h1;
	localparam logic [2:0] IDX_MASTER = 3'h2;
	localparam logic [2:0] IDX_PLAIN = 3'h3;
	localparam logic [2:0] IDX_DEC_DATA = 3'h4;
	localparam logic [2:0] IDX_ENC_DATA = 3'h5;
	localparam logic [2:0] IDX_DEC_SKEY = 3'h6;
	localparam logic [2:0] IDX_ENC_SKEY = 3'h7;
	localparam logic [2:0] IDX_RD_XFER = 3'h1;
	localparam logic [2:0] IDX_RD_STATUS = 3'h2;
	localparam logic [2:0] IDX_RD_DATA = 3'h4;

	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam int STAT_FAULT_BIT = 7;
	localparam int STAT_BUSY_BIT = 6;

	typedef enum logic [2:0] {
		OP_ENC = 3'h1,
		OP_DEC = 3'h2,
		OP_XFER = 3'h4
	} op_t;

	typedef enum logic [3:0] {
		SEQ_IDLE = 4'h1,
		SEQ_MASTER = 4'h2,
		SEQ_PLAIN = 4'h4,
		SEQ_STAGE = 4'h8
	} seq_t;

	typedef enum logic [2:0] {
		DST_DATA = 3'h1,
		DST_SKEY = 3'h2,
		DST_XFER = 3'h4
	} dest_t;

	typedef enum logic [1:0] {
		ENG_IDLE = 2'h1,
		ENG_RUN = 2'h2
	} eng_state_t;

	// A key character is odd over all eight bits, parity in bit 0.
	function automatic logic byte_parity_bad(input logic [7:0] b);
		byte_parity_bad = ~(^b);
	endfunction

	function automatic logic key_parity_bad(input logic [63:0] k);
		key_parity_bad = 1'h0;
		for (int i = 0; i < 8; i++) begin
			key_parity_bad = key_parity_bad | byte_parity_bad(k[i*8 +: 8]);
		end
	endfunction

endpackage

// ---- src/cipher_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface cipher_if;
	import des_key_pkg::*;
	logic start;
	logic abort;
	logic tick;
	op_t op;
	logic [8:0] len;
	logic [63:0] key;
	logic [63:0] din;
	logic busy;
	logic done;
	logic [63:0] dout;
	modport ctrl(output start, abort, tick, op, len, key, din,
		input busy, done, dout);
	modport eng(input start, abort, tick, op, len, key, din,
		output busy, done, dout);
endinterface
`default_nettype wire

// ---- src/cipher_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
module cipher_engine
	import des_key_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	cipher_if.eng cif
);
	eng_state_t state_reg;
	op_t op_reg;
	logic [8:0] len_reg;
	logic [8:0] cnt_reg;
	logic [63:0] key_reg;
	logic [63:0] din_reg;
	logic [63:0] dout_reg;
	logic done_reg;
	logic last;
	logic [12:0] run_cyc_reg;

	// The round network is a reversible stand-in; only the timing and
	// the load paths are exact. A real round core drops in behind mix.
	function automatic logic [63:0] mix(input op_t o, input logic [63:0] k,
		input logic [63:0] d);
		logic [63:0] x;
		x = d ^ k;
		case (o)
		OP_ENC: mix = {x[55:0], x[63:56]};
		OP_DEC: mix = {d[7:0], d[63:8]} ^ k;
		default: mix = k;
		endcase
	endfunction

	assign last = cif.tick && cnt_reg == 9'(len_reg - 9'h001);
	assign cif.busy = state_reg == ENG_RUN;
	assign cif.done = done_reg;
	assign cif.dout = dout_reg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ENG_IDLE;
		end else if (cif.abort) begin
			state_reg <= ENG_IDLE;
		end else begin
			case (state_reg)
			ENG_IDLE: if (cif.start) state_reg <= ENG_RUN;
			ENG_RUN: if (last) state_reg <= ENG_IDLE;
			default: state_reg <= ENG_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 9'h000;
			op_reg <= OP_XFER;
			len_reg <= CYC_XFER;
			key_reg <= 64'h0000_0000_0000_0000;
			din_reg <= 64'h0000_0000_0000_0000;
		end else if (state_reg == ENG_IDLE && cif.start) begin
			cnt_reg <= 9'h000;
			op_reg <= cif.op;
			len_reg <= cif.len;
			key_reg <= cif.key;
			din_reg <= cif.din;
		end else if (state_reg == ENG_RUN && cif.tick) begin
			cnt_reg <= cnt_reg + 9'h001; // see RL9
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			done_reg <= 1'h0;
			dout_reg <= 64'h0000_0000_0000_0000;
		end else begin
			done_reg <= state_reg == ENG_RUN && last && !cif.abort;
			if (state_reg == ENG_RUN && last) begin
				dout_reg <= mix(op_reg, key_reg, din_reg);
			end
		end
	end

	// Counts mclk cycles rather than ticks, so a skipped or doubled tick
	// shows up against the spacing of the divider.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			run_cyc_reg <= 13'h0000;
		end else if (state_reg == ENG_IDLE && cif.start) begin
			run_cyc_reg <= 13'h0000;
		end else if (state_reg == ENG_RUN) begin
			run_cyc_reg <= run_cyc_reg + 13'h0001;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	done_tick_count_a: assert property (cif.done |-> // see RL9
		run_cyc_reg > (len_reg - 9'h001) * ALGO_DIV &&
		run_cyc_reg <= len_reg * ALGO_DIV)
		else $error("engine finished after the wrong number of ticks");
	abort_stops_a: assert property (cif.abort |=> !cif.busy ##1 !cif.done) // see RL3
		else $error("engine kept running after abort");

endmodule
`default_nettype wire

// ---- src/des_key_ctrl.sv ----
// Summary of operation
// RL1 - Software reset accepted at any time.
// RL2 - Resets clear control, flags, counters; keep keys.
// RL3 - Reset during algorithm keeps master key.
// RL4 - Eight master writes load working and master.
// RL5 - Master key load is parity checked.
// RL6 - Eight plain writes load working key only.
// RL7 - Seven staged plus encipher loads working key.
// RL8 - Seven staged plus decipher loads working key.
// RL9 - Session key cipher takes 328 algorithm cycles.
// RL10 - Transfer read copies master into working key.
// RL11 - Key transfer takes eight algorithm cycles.
// RL12 - Key is eight characters, seven bits plus parity.
// RL13 - Parity in D0, odd over whole byte.
// RL14 - Host may leave parity bits zero.
// RL15 - Host resets then loads master key first.
// RL16 - Host writes eight, reads eight per block.
// RL17 - Feedback buffer starts with agreed fill.
// RL18 - Feedback encipher: XOR keystream, shift, reload.
// RL19 - Feedback decipher: XOR, shift received, reload, read.
// RL20 - Address and direction select eleven operations.
// RL21 - While busy only status and resets count.
// RL22 - Parity fault holds pin low until reset.
// RL23 - Ready pin inactive while busy, active idle.
// RL24 - Key byte counter advances, cleared by reset.
// RL25 - Any even character sets fault after eighth.
`timescale 1ns/1ps
`default_nettype none
module des_key_ctrl
	import des_key_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic parity_irq_out,
	output logic parity_irq_out_oe_n,
	output logic ready_irq_out,
	output logic ready_irq_out_oe_n
);
	cipher_if cif();

	logic [2:0] idx;
	logic addr_ok;
	logic acc_rd;
	logic wr_ph_reg;
	logic [2:0] wr_idx_reg;
	logic [7:0] wbyte;
	logic busy_all;
	logic soft_rst;
	logic wr_go;
	logic wr_master, wr_plain, wr_stage;
	logic wr_enc_skey, wr_dec_skey, wr_enc_data, wr_dec_data;
	logic wr_trig;
	logic rd_xfer, rd_data;
	seq_t seq_reg;
	seq_t wr_kind;
	logic [2:0] key_cnt_reg;
	logic [2:0] cnt_base;
	logic load_key, key_last, key_bad;
	logic [55:0] kbuf_reg;
	logic perr_acc_reg;
	logic [63:0] new_key;
	logic [63:0] master_key_reg;
	logic [63:0] work_key_reg;
	logic master_set_reg;
	logic [63:0] data_reg;
	logic start_reg;
	op_t eng_op_reg;
	logic [8:0] eng_len_reg;
	logic [63:0] eng_key_reg;
	logic [63:0] eng_din_reg;
	dest_t dest_reg;
	logic fault_reg;
	logic fault_set;
	logic [7:0] rd_reg;
	logic [4:0] div_cnt_reg;
	logic tick_reg;

	function automatic logic hit(input logic en, input logic [2:0] a,
		input logic [2:0] b);
		hit = en && a == b;
	endfunction

	cipher_engine u_engine (
		.mclk(mclk),
		.rst_n(rst_n),
		.cif(cif)
	);

	// Zero wait states: every access completes in its data phase.
	assign hreadyout = 1'h1;
	assign hresp = 1'h0;
	assign hrdata = {24'h00_0000, rd_reg};

	assign idx = haddr[4:2];
	assign addr_ok = hsel && htrans[1] && hready && hsize == HSIZE_WORD &&
		haddr[31:5] == 27'h000_0000 && haddr[1:0] == 2'h0;
	assign acc_rd = addr_ok && !hwrite;
	assign wbyte = hwdata[7:0];

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ph_reg <= 1'h0;
			wr_idx_reg <= 3'h0;
		end else begin
			wr_ph_reg <= addr_ok && hwrite;
			wr_idx_reg <= idx;
		end
	end

	// The done cycle counts as busy so a read cannot race the result load.
	assign busy_all = cif.busy || start_reg || cif.done;
	assign soft_rst = hit(wr_ph_reg, wr_idx_reg, IDX_RESET); // see RL1
	assign wr_go = wr_ph_reg && !busy_all && !soft_rst; // see RL21
	assign wr_master = hit(wr_go, wr_idx_reg, IDX_MASTER); // see RL20
	assign wr_plain = hit(wr_go, wr_idx_reg, IDX_PLAIN);
	assign wr_stage = hit(wr_go, wr_idx_reg, IDX_STAGE);
	assign wr_enc_skey = hit(wr_go, wr_idx_reg, IDX_ENC_SKEY);
	assign wr_dec_skey = hit(wr_go, wr_idx_reg, IDX_DEC_SKEY);
	assign wr_enc_data = hit(wr_go, wr_idx_reg, IDX_ENC_DATA);
	assign wr_dec_data = hit(wr_go, wr_idx_reg, IDX_DEC_DATA);
	assign wr_trig = wr_enc_skey || wr_dec_skey || wr_enc_data ||
		wr_dec_data;
	// A trigger write in the same cycle wins; the read is then ignored.
	assign rd_xfer = hit(acc_rd && !busy_all && !wr_trig, idx,
		IDX_RD_XFER); // see RL10
	assign rd_data = hit(acc_rd, idx, IDX_RD_DATA);

	always_comb begin
		wr_kind = SEQ_IDLE;
		if (wr_master) wr_kind = SEQ_MASTER;
		else if (wr_plain) wr_kind = SEQ_PLAIN;
		else if (wr_stage) wr_kind = SEQ_STAGE;
	end

	// Any other accepted write breaks a run of consecutive key bytes.
	assign cnt_base = (seq_reg == wr_kind) ? key_cnt_reg : 3'h0;
	assign load_key = wr_master || wr_plain;
	assign key_last = load_key && cnt_base == KEY_BYTES_LAST; // see RL12
	assign new_key = {kbuf_reg, wbyte};
	assign key_bad = ((seq_reg == wr_kind) && perr_acc_reg) ||
		byte_parity_bad(wbyte); // see RL13

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			seq_reg <= SEQ_IDLE;
			key_cnt_reg <= 3'h0;
		end else if (soft_rst) begin
			seq_reg <= SEQ_IDLE; // see RL2
			key_cnt_reg <= 3'h0; // see RL24
		end else if (key_last) begin
			seq_reg <= SEQ_IDLE;
			key_cnt_reg <= 3'h0;
		end else if (load_key) begin
			seq_reg <= wr_kind;
			key_cnt_reg <= cnt_base + 3'h1; // see RL24
		end else if (wr_stage) begin
			seq_reg <= SEQ_STAGE;
			if (cnt_base != KEY_BYTES_LAST) begin
				key_cnt_reg <= cnt_base + 3'h1;
			end else begin
				key_cnt_reg <= cnt_base;
			end
		end else if (wr_go) begin
			seq_reg <= SEQ_IDLE;
			key_cnt_reg <= 3'h0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			kbuf_reg <= 56'h00_0000_0000_0000;
			perr_acc_reg <= 1'h0;
		end else if (soft_rst) begin
			perr_acc_reg <= 1'h0;
		end else if (load_key) begin
			kbuf_reg <= new_key[55:0];
			perr_acc_reg <= key_bad; // see RL5
		end
	end

	// Key stores carry no reset so that neither reset disturbs them.
	always_ff @(posedge mclk) begin
		if (key_last && wr_master) begin
			master_key_reg <= new_key; // see RL4
		end
	end

	always_ff @(posedge mclk) begin
		if (key_last) begin
			work_key_reg <= new_key; // see RL4 see RL6
		end else if (cif.done && !soft_rst && dest_reg != DST_DATA) begin
			work_key_reg <= cif.dout; // see RL7 see RL8 see RL10
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			master_set_reg <= 1'h0;
		end else if (key_last && wr_master) begin
			master_set_reg <= 1'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			data_reg <= 64'h0000_0000_0000_0000;
		end else if (soft_rst && busy_all) begin
			data_reg <= 64'h0000_0000_0000_0000; // see RL3
		end else if (wr_stage || wr_trig) begin
			data_reg <= {data_reg[55:0], wbyte};
		end else if (cif.done && !soft_rst && dest_reg == DST_DATA) begin
			data_reg <= cif.dout;
		end else if (rd_data && !busy_all) begin
			// Zeros follow each byte out so no result lingers.
			data_reg <= {data_reg[55:0], 8'h00};
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			start_reg <= 1'h0;
			eng_op_reg <= OP_XFER;
			eng_len_reg <= CYC_XFER;
			eng_key_reg <= 64'h0000_0000_0000_0000;
			eng_din_reg <= 64'h0000_0000_0000_0000;
			dest_reg <= DST_DATA;
		end else begin
			start_reg <= wr_trig || rd_xfer;
			if (wr_enc_skey || wr_dec_skey) begin
				eng_op_reg <= wr_enc_skey ? OP_ENC : OP_DEC; // see RL7 see RL8
				eng_len_reg <= CYC_SKEY; // see RL9
				eng_key_reg <= master_key_reg;
				eng_din_reg <= {data_reg[55:0], wbyte};
				dest_reg <= DST_SKEY;
			end else if (wr_enc_data || wr_dec_data) begin
				eng_op_reg <= wr_enc_data ? OP_ENC : OP_DEC;
				eng_len_reg <= CYC_DATA;
				eng_key_reg <= work_key_reg;
				eng_din_reg <= {data_reg[55:0], wbyte};
				dest_reg <= DST_DATA;
			end else if (rd_xfer) begin
				eng_op_reg <= OP_XFER;
				eng_len_reg <= CYC_XFER; // see RL11
				eng_key_reg <= master_key_reg;
				dest_reg <= DST_XFER;
			end
		end
	end

	assign cif.start = start_reg;
	assign cif.abort = soft_rst; // see RL3
	assign cif.tick = tick_reg;
	assign cif.op = eng_op_reg;
	assign cif.len = eng_len_reg;
	assign cif.key = eng_key_reg;
	assign cif.din = eng_din_reg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_reg <= 5'h00;
			tick_reg <= 1'h0;
		end else begin
			tick_reg <= div_cnt_reg == ALGO_DIV_LAST;
			if (div_cnt_reg == ALGO_DIV_LAST) begin
				div_cnt_reg <= 5'h00;
			end else begin
				div_cnt_reg <= div_cnt_reg + 5'h01;
			end
		end
	end

	// Data blocks also check the working key they run under.
	assign fault_set = (key_last && key_bad) ||
		(cif.done && !soft_rst && dest_reg == DST_SKEY &&
		key_parity_bad(cif.dout)) ||
		((wr_enc_data || wr_dec_data) && key_parity_bad(work_key_reg));

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fault_reg <= 1'h0;
		end else if (fault_set) begin
			fault_reg <= 1'h1; // see RL25 see RL7 see RL8
		end else if (soft_rst) begin
			fault_reg <= 1'h0; // see RL22
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_reg <= 8'h00;
		end else if (acc_rd) begin
			case (idx)
			IDX_RD_STATUS: begin
				rd_reg <= 8'h00;
				rd_reg[STAT_FAULT_BIT] <= fault_reg;
				rd_reg[STAT_BUSY_BIT] <= busy_all;
			end
			IDX_RD_DATA: rd_reg <= busy_all ? 8'h00 : data_reg[63:56];
			default: rd_reg <= 8'h00; // see RL10
			endcase
		end
	end

	// Open-drain pins: low enable means the pin is pulled low.
	assign parity_irq_out = 1'h0;
	assign parity_irq_out_oe_n = !fault_reg; // see RL22
	assign ready_irq_out = 1'h0;
	assign ready_irq_out_oe_n = busy_all; // see RL23

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence master_eighth_s;
		wr_master && cnt_base == KEY_BYTES_LAST;
	endsequence

	sequence xfer_done_s;
		##[100:200] (cif.done && dest_reg == DST_XFER);
	endsequence

	soft_clears_fault_a: assert property (soft_rst |=> !fault_reg) // see RL2
		else $error("fault flag survived software reset");
	fault_sticky_a: assert property (fault_reg && !soft_rst |=> fault_reg) // see RL22
		else $error("fault flag dropped without reset");
	master_keep_a: assert property (master_set_reg && soft_rst |=>
		$stable(master_key_reg)) // see RL3
		else $error("master key changed by software reset");
	master_load_a: assert property (master_eighth_s |=>
		master_key_reg == work_key_reg && master_set_reg) // see RL4
		else $error("master load did not fill both keys");
	plain_keep_a: assert property (wr_plain && key_last && master_set_reg
		|=> $stable(master_key_reg)) // see RL6
		else $error("plain key load touched master key");
	busy_ignore_a: assert property (busy_all && wr_ph_reg &&
		wr_idx_reg == IDX_MASTER |=> $stable(key_cnt_reg)) // see RL21
		else $error("key byte accepted while busy");
	cnt_clear_a: assert property (soft_rst |=> key_cnt_reg == 3'h0) // see RL24
		else $error("key byte counter not cleared");
	parity_flag_a: assert property (key_last && key_bad |=>
		fault_reg ##1 !parity_irq_out_oe_n) // see RL5
		else $error("bad key character not flagged");
	ready_busy_a: assert property (rd_xfer |=> ready_irq_out_oe_n[*8]) // see RL23
		else $error("ready pin active during key transfer");
	xfer_copy_a: assert property (disable iff (!rst_n || soft_rst)
		rd_xfer && master_set_reg |-> xfer_done_s ##1
		work_key_reg == master_key_reg) // see RL11
		else $error("key transfer late or wrong");
	skey_len_a: assert property (wr_enc_skey |=> eng_len_reg == CYC_SKEY
		&& eng_op_reg == OP_ENC && cif.start) // see RL9
		else $error("session key encipher set up wrongly");

endmodule
`default_nettype wire

// ---- bench/ahb_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module ahb_host
	import des_key_pkg::*;
(
	input wire logic mclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0000_0000;
	end

	// Waits for hready at a rising edge; the bound only guards a hang.
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hready !== 1'b1 && n < 64);
	endtask

	// Command select is the word index on the address lines.
	task automatic addr_phase(input logic [2:0] idx, input logic wr);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {27'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
	endtask

	task automatic write_byte(input logic [2:0] idx, input logic [7:0] d);
		addr_phase(idx, 1'b1);
		hwdata <= {24'h00_0000, d};
		wait_ready();
		// Released data is scrambled so a stale value never looks valid.
		hwdata <= ~{24'h00_0000, d};
	endtask

	task automatic read_word(input logic [2:0] idx, output logic [31:0] q);
		addr_phase(idx, 1'b0);
		wait_ready();
		q = hrdata;
	endtask
endmodule
`default_nettype wire

// ---- bench/des_key_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module des_key_ctrl_test;
	import des_key_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	logic par_pin;
	logic par_oe_n;
	logic rdy_pin;
	logic rdy_oe_n;
	int err_count = 0;
	int total_checks = 0;
	logic [63:0] good_key = 64'h70A1_1045_4A1A_6E57;
	logic [63:0] block = 64'h0123_4567_89AB_CDEF;

	always #12.5 mclk = ~mclk;

	des_key_ctrl u_des_key_ctrl(.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .parity_irq_out(par_pin),
		.parity_irq_out_oe_n(par_oe_n), .ready_irq_out(rdy_pin),
		.ready_irq_out_oe_n(rdy_oe_n));

	ahb_host u_ahb_host(.mclk(mclk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata));

	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d, errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Byte 1 is the most significant character of the key.
	task automatic send_bytes(input logic [2:0] idx, input logic [63:0] k,
		input int cnt);
		for (int i = 0; i < cnt; i++) begin
			u_ahb_host.write_byte(idx, k[63 - 8 * i -: 8]);
		end
	endtask

	task automatic stage_then(input logic [2:0] idx, input logic [63:0] k);
		send_bytes(IDX_STAGE, k, 7);
		u_ahb_host.write_byte(idx, k[7:0]);
	endtask

	task automatic status(input logic [7:0] exp, input string msg);
		logic [31:0] q;
		u_ahb_host.read_word(IDX_RD_STATUS, q);
		chk(q === {24'h00_0000, exp}, msg);
	endtask

	// Counts cycles with the ready pin released after a trigger.
	task automatic busy_span(output int n);
		int w;
		w = 0;
		n = 0;
		while (rdy_oe_n !== 1'b1 && w < 8) begin
			@(negedge mclk);
			w++;
		end
		while (rdy_oe_n === 1'b1 && n < 10000) begin
			@(negedge mclk);
			n++;
		end
	endtask

	task automatic t_reset();
		@(negedge mclk);
		chk(hreadyout === 1'b1 && hresp === 1'b0, "bus idle state");
		chk(par_oe_n === 1'b1 && par_pin === 1'b0, "parity pin");
		chk(rdy_oe_n === 1'b0 && rdy_pin === 1'b0, "ready pin");
		status(8'h00, "status after reset");
	endtask

	task automatic t_master();
		send_bytes(IDX_MASTER, good_key, 8);
		status(8'h00, "good master key");
		chk(par_oe_n === 1'b1, "no parity fault");
	endtask

	// All-zero parity bits are allowed by the host but are flagged.
	task automatic t_plain_bad();
		send_bytes(IDX_PLAIN, 64'h0, 7);
		status(8'h00, "no fault before eighth byte");
		send_bytes(IDX_PLAIN, 64'h0, 1);
		status(8'h80, "fault after eighth byte");
		chk(par_oe_n === 1'b0, "parity pin low");
		u_ahb_host.write_byte(IDX_RESET, 8'h00);
		status(8'h00, "fault cleared");
		chk(par_oe_n === 1'b1, "parity pin released");
	endtask

	// Working key is still bad after reset, so a data op faults.
	task automatic t_abort();
		stage_then(IDX_ENC_DATA, block);
		repeat (4) @(negedge mclk);
		chk(rdy_oe_n === 1'b1, "ready released while busy");
		status(8'hC0, "busy with kept bad key");
		u_ahb_host.write_byte(IDX_RESET, 8'h00);
		repeat (3) @(negedge mclk);
		chk(rdy_oe_n === 1'b0, "abort ends busy");
		status(8'h00, "status after abort");
	endtask

	// A good result proves the master key survived aborts and ignores.
	task automatic t_xfer();
		logic [31:0] q;
		int n;
		u_ahb_host.read_word(IDX_RD_XFER, q);
		busy_span(n);
		chk(n >= 8 * ALGO_DIV - 20 && n <= 8 * ALGO_DIV + 20, "xfer time");
		stage_then(IDX_DEC_DATA, block);
		busy_span(n);
		chk(n > 300 * ALGO_DIV, "data op ran");
		status(8'h00, "working key equals master");
	endtask

	task automatic t_skey(input logic [2:0] idx);
		logic [31:0] q;
		int n;
		q = 32'hFFFF_FFFF;
		stage_then(idx, good_key);
		fork
			busy_span(n);
			begin
				u_ahb_host.read_word(IDX_RD_DATA, q);
				send_bytes(IDX_MASTER, 64'h0, 8);
			end
		join
		chk(n >= 328 * ALGO_DIV - 20 && n <= 328 * ALGO_DIV + 20, "skey time");
		chk(q === 32'h0000_0000, "data read while busy");
		// The stand-in round leaves even characters in this new key.
		status(8'h80, "new session key parity checked");
		u_ahb_host.write_byte(IDX_RESET, 8'h00);
	endtask

	// Runs one block through the device and waits until it is idle.
	task automatic run_block(input logic [2:0] idx, input logic [63:0] d);
		int n;
		stage_then(idx, d);
		busy_span(n);
	endtask

	// Reads cnt result bytes; the last byte read lands in q[7:0].
	task automatic read_bytes(input int cnt, output logic [63:0] q);
		logic [31:0] w;
		q = 64'h0000_0000_0000_0000;
		for (int i = 0; i < cnt; i++) begin
			u_ahb_host.read_word(IDX_RD_DATA, w);
			q = {q[55:0], w[7:0]};
		end
	endtask

	// Write eight, read eight; the reverse direction restores the block.
	task automatic t_block();
		logic [63:0] c;
		logic [63:0] p;
		run_block(IDX_ENC_DATA, block);
		read_bytes(8, c);
		chk(c !== block, "enciphered block unchanged");
		run_block(IDX_DEC_DATA, c);
		read_bytes(8, p);
		chk(p === block, "block round trip");
		read_bytes(1, p);
		chk(p[7:0] === 8'h00, "zeros after eight reads");
	endtask

	// One end of a feedback link. Both ends run the block cipher forward,
	// so the receiver only has to feed back the bytes it received.
	task automatic cfb_run(input logic rx, input logic [15:0] din,
		output logic [15:0] dout);
		logic [63:0] fill;
		logic [63:0] k;
		logic [7:0] c;
		dout = 16'h0000;
		fill = block;
		for (int i = 0; i < 2; i++) begin
			run_block(IDX_ENC_DATA, fill);
			read_bytes(1, k);
			dout = {dout[7:0], din[15 - 8 * i -: 8] ^ k[7:0]};
			c = rx ? din[15 - 8 * i -: 8] : dout[7:0];
			fill = {fill[55:0], c};
		end
	endtask

	task automatic t_cfb();
		logic [15:0] c;
		logic [15:0] p;
		cfb_run(1'b0, 16'h4869, c);
		chk(c[15:8] !== 8'h48, "feedback cipher byte");
		cfb_run(1'b1, c, p);
		chk(p === 16'h4869, "feedback round trip");
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		// Reset first, then the master key, as a link host would.
		u_ahb_host.write_byte(IDX_RESET, 8'h00);
		t_master();
		t_plain_bad();
		t_abort();
		t_xfer();
		t_skey(IDX_ENC_SKEY);
		t_skey(IDX_DEC_SKEY);
		t_xfer();
		t_block();
		t_cfb();
		print_verdict();
	end

	// About 1.4 times the expected run length.
	initial begin
		repeat (90000) @(posedge mclk);
		err_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
